//--- hw/vic_clkgen.sv
// Capture clock pin handling: edge detect in input mode, divider in output mode.
// Assumes the pin input is already synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module vic_clkgen
   import vic_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       clk_out,
   input  wire logic [7:0] div,
   input  wire logic       pin_i,
   output logic            pin_o,
   output logic            pin_oe,
   output logic            edge_en
);

   logic [7:0] cnt_r;
   logic [7:0] cnt_nxt;
   logic [7:0] div_eff;
   logic       pin_o_r;
   logic       rise_r;
   logic       prev_r;

   // ==========================================================================
   // Divider
   // Divisors below two would leave no high phase
   assign div_eff = (div < VIC_DIV_MIN) ? VIC_DIV_MIN : div;
   assign cnt_nxt = (cnt_r >= div_eff - 8'h01) ? 8'h00 : cnt_r + 8'h01; // [R6]

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         cnt_r   <= 8'h00;
         pin_o_r <= 1'b0;
         rise_r  <= 1'b0;
      end
      else
      begin
         cnt_r   <= cnt_nxt;
         pin_o_r <= clk_out && (cnt_nxt < (div_eff >> 1)); // [R6]
         rise_r  <= clk_out && (cnt_nxt == 8'h00);
      end
   end

   // ==========================================================================
   // Input edge detect
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         prev_r <= 1'b0;
      else
         prev_r <= pin_i;
   end

   assign pin_o   = pin_o_r;
   assign pin_oe  = clk_out; // [R1] [R6]
   assign edge_en = clk_out ? rise_r : (pin_i && !prev_r); // [R2]

endmodule
`default_nettype wire

//--- hw/vic_pkg.sv
// Constants, field layout and carrier types of the video input capture port.
// Assumes one core clock at 125 MHz and an AHB-Lite register bus.
//
// Summary of operation
// R1: Capture clock pin is direction programmable and comes out of reset as input.
// R2: Input clock mode samples all ten bus lines on rising edges while qualified. In YUV8 format the upper two are stored as zero here.
// R3: A rising edge with the qualifier low records nothing.
// R4: Capture rates up to 81 MHz; the source never exceeds that rate. Edge detect here tops out at half the 125 MHz core rate.
// R5: Optional mode samples the two marker lines in message mode regardless of qualifier.
// R6: Output clock mode drives the pin at core clock over a programmable integer.
// R7: Low eight lines carry YUV 4:2:2 bytes or general high speed data.
// R8: Upper two lines extend samples to ten bits in ten bit raw mode.
// R9: In message mode line 8 marks message start and line 9 marks message end.
// R10: Direction, divisor, format and bypass are software settings, locked while enabled.
package vic_pkg;

   // ==========================================================================
   // Register map
   localparam logic [7:0] VIC_OFS_CTRL = 8'h00;
   localparam logic [7:0] VIC_OFS_DIV  = 8'h04;
   localparam logic [7:0] VIC_OFS_STAT = 8'h08;
   localparam logic [7:0] VIC_OFS_DATA = 8'h0C;
   localparam logic [7:0] VIC_OFS_CNT  = 8'h10;

   // ==========================================================================
   // Field positions
   localparam int VIC_CTRL_EN   = 0;
   localparam int VIC_CTRL_DIR  = 1;
   localparam int VIC_CTRL_BYP  = 2;
   localparam int VIC_CTRL_FMT  = 4;
   localparam int VIC_STAT_AVL  = 0;
   localparam int VIC_STAT_OVR  = 1;
   localparam int VIC_STAT_STA  = 2;
   localparam int VIC_STAT_END  = 3;

   // ==========================================================================
   // Reset values and limits
   localparam logic [7:0]  VIC_DIV_RST = 8'h04;
   localparam logic [7:0]  VIC_DIV_MIN = 8'h02;
   localparam logic [15:0] VIC_CNT_RST = 16'h0000;

   // ==========================================================================
   // Timing
   localparam int VIC_CORE_MHZ    = 125;
   localparam int VIC_MAX_CAP_MHZ = 81;
   // Least core cycles between two capture edges at the fastest source rate
   localparam int VIC_MIN_EDGE_GAP = (VIC_CORE_MHZ + VIC_MAX_CAP_MHZ - 1) / VIC_MAX_CAP_MHZ;

   // ==========================================================================
   // Types
   typedef enum logic [1:0] {
      VIC_FMT_YUV8  = 2'b00,
      VIC_FMT_TEN_BIT_RAW_MODE = 2'b01,
      VIC_FMT_MSG   = 2'b10
   } vic_fmt_t;

   typedef struct packed {
      logic [9:0] data;
      logic       msg_start;
      logic       msg_end;
   } vic_sample_t;

   typedef struct packed {
      logic       enable;
      logic       clk_out;
      logic       bypass;
      vic_fmt_t   fmt;
      logic [7:0] div;
   } vic_cfg_t;

endpackage

//--- hw/vic_sampler.sv
// Qualified capture of the ten bit bus on each capture edge.
// Assumes edge_en is a one cycle strobe and bus inputs are synchronous.
`timescale 1ns/1ps
`default_nettype none
module vic_sampler
   import vic_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        enable,
   input  wire vic_fmt_t    fmt,
   input  wire logic        bypass,
   input  wire logic        edge_en,
   input  wire logic        qual,
   input  wire logic [9:0]  bus,
   output logic             smp_valid,
   output vic_sample_t      smp
);

   logic       mark_ok;
   logic [9:0] data_r;
   logic       start_r;
   logic       end_r;

   // One driver per field: the struct is assembled from separate flops
   assign smp = {data_r, start_r, end_r};

   // Markers may ignore the qualifier so framing survives blanking
   assign mark_ok = (fmt == VIC_FMT_MSG) && (qual || bypass); // [R5] [R9]

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         smp_valid <= 1'b0;
         start_r   <= 1'b0;
         end_r     <= 1'b0;
      end
      else
      begin
         smp_valid <= enable && edge_en && qual; // [R2] [R3]
         start_r   <= enable && edge_en && mark_ok && bus[8]; // [R9]
         end_r     <= enable && edge_en && mark_ok && bus[9]; // [R9]
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         data_r <= 10'h000;
      else if (enable && edge_en && qual) // [R3]
      begin
         data_r[7:0] <= bus[7:0]; // [R7]
         data_r[9:8] <= (fmt == VIC_FMT_YUV8) ? 2'b00 : bus[9:8]; // [R8]
      end
   end

endmodule
`default_nettype wire

//--- hw/vic_top.sv
// Video input capture port top: AHB-Lite register slave, clock pin, sampler.
// Assumes a single AHB-Lite master, word transfers, and synchronous pin inputs.
`timescale 1ns/1ps
`default_nettype none
module vic_top
   import vic_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   input  wire logic        capture_clock_pin_i,
   output logic             capture_clock_pin_o,
   output logic             capture_clock_pin_oe,
   input  wire logic        capture_qualifier,
   input  wire logic [9:0]  capture_bus,
   output logic             cap_valid,
   output vic_sample_t      cap_sample
);

   // ==========================================================================
   // Declarations
   vic_cfg_t    cfg_r;
   logic        avail_r;
   logic        ovr_r;
   logic        sta_r;
   logic        end_r;
   logic [9:0]  data_r;
   logic [15:0] cnt_r;
   logic [31:0] hrdata_r;
   logic        wr_pend_r;
   logic [7:0]  wr_addr_r;
   logic        acc;
   logic        rd_acc;
   logic        wr_ctrl;
   logic        wr_div;
   logic        wr_stat;
   logic        rd_data;
   logic        edge_en;
   logic        smp_valid;
   vic_sample_t smp;
   logic [31:0] ctrl_word;
   logic [31:0] stat_word;

   function automatic logic [31:0] vic_read(input logic [7:0] ofs,
                                            input logic [31:0] ctrl,
                                            input logic [31:0] stat,
                                            input logic [7:0] dv,
                                            input logic [9:0] dat,
                                            input logic [15:0] cnt);
      logic [31:0] r;
      r = 32'h0000_0000;
      unique case (ofs)
         VIC_OFS_CTRL: r = ctrl;
         VIC_OFS_DIV:  r = {24'h00_0000, dv};
         VIC_OFS_STAT: r = stat;
         VIC_OFS_DATA: r = {22'h00_0000, dat};
         VIC_OFS_CNT:  r = {16'h0000, cnt};
         default:      r = 32'h0000_0000;
      endcase
      return r;
   endfunction

   // ==========================================================================
   // AHB-Lite slave
   // Zero wait states; unmapped offsets read zero and ignore writes
   assign acc    = hsel && htrans[1] && hready && (hsize == 3'b010);
   assign rd_acc = acc && !hwrite;
   assign rd_data = rd_acc && (haddr[7:0] == VIC_OFS_DATA) && (haddr[31:8] == 24'h00_0000);
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = hrdata_r;

   assign wr_ctrl = wr_pend_r && (wr_addr_r == VIC_OFS_CTRL);
   assign wr_div  = wr_pend_r && (wr_addr_r == VIC_OFS_DIV);
   assign wr_stat = wr_pend_r && (wr_addr_r == VIC_OFS_STAT);

   assign ctrl_word = {26'h000_0000, cfg_r.fmt, 1'b0, cfg_r.bypass, cfg_r.clk_out,
                       cfg_r.enable};
   assign stat_word = {28'h000_0000, end_r, sta_r, ovr_r, avail_r};

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= 8'h00;
      end
      else
      begin
         wr_pend_r <= acc && hwrite && (haddr[31:8] == 24'h00_0000);
         wr_addr_r <= haddr[7:0];
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         hrdata_r <= 32'h0000_0000;
      else if (rd_acc)
      begin
         if (haddr[31:8] == 24'h00_0000)
            hrdata_r <= vic_read(haddr[7:0], ctrl_word, stat_word, cfg_r.div, data_r, cnt_r);
         else
            hrdata_r <= 32'h0000_0000;
      end
   end

   // ==========================================================================
   // Configuration
   // Everything but the enable bit is frozen during capture
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         cfg_r.enable  <= 1'b0;
         cfg_r.clk_out <= 1'b0; // [R1]
         cfg_r.bypass  <= 1'b0;
         cfg_r.fmt     <= VIC_FMT_YUV8;
         cfg_r.div     <= VIC_DIV_RST;
      end
      else
      begin
         if (wr_ctrl)
         begin
            cfg_r.enable <= hwdata[VIC_CTRL_EN];
            if (!cfg_r.enable) // [R10]
            begin
               cfg_r.clk_out <= hwdata[VIC_CTRL_DIR];
               cfg_r.bypass  <= hwdata[VIC_CTRL_BYP];
               cfg_r.fmt     <= vic_fmt_t'(hwdata[VIC_CTRL_FMT +: 2]);
            end
         end
         if (wr_div && !cfg_r.enable) // [R10]
            cfg_r.div <= hwdata[7:0];
      end
   end

   // ==========================================================================
   // Status and capture data
   // Hardware set beats software clear in every sticky flag
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         avail_r <= 1'b0;
         ovr_r   <= 1'b0;
         sta_r   <= 1'b0;
         end_r   <= 1'b0;
      end
      else
      begin
         if (smp_valid)
            avail_r <= 1'b1;
         else if (rd_data)
            avail_r <= 1'b0;
         if (smp_valid && avail_r && !rd_data)
            ovr_r <= 1'b1;
         else if (wr_stat && hwdata[VIC_STAT_OVR])
            ovr_r <= 1'b0;
         if (smp.msg_start) // [R9]
            sta_r <= 1'b1;
         else if (wr_stat && hwdata[VIC_STAT_STA])
            sta_r <= 1'b0;
         if (smp.msg_end) // [R9]
            end_r <= 1'b1;
         else if (wr_stat && hwdata[VIC_STAT_END])
            end_r <= 1'b0;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         data_r <= 10'h000;
      else if (smp_valid)
         data_r <= smp.data;
   end

   // Count restarts when capture is switched on
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         cnt_r <= VIC_CNT_RST;
      else if (wr_ctrl && hwdata[VIC_CTRL_EN] && !cfg_r.enable)
         cnt_r <= VIC_CNT_RST;
      else if (smp_valid)
         cnt_r <= cnt_r + 16'h0001;
   end

   // ==========================================================================
   // Clock pin and sampler
   // Synchronous edge detect tops out at half the core rate in input mode
   vic_clkgen u_clkgen
   (
      .clk     (clk),
      .rst_n   (rst_n),
      .clk_out (cfg_r.clk_out),
      .div     (cfg_r.div),
      .pin_i   (capture_clock_pin_i),
      .pin_o   (capture_clock_pin_o),
      .pin_oe  (capture_clock_pin_oe),
      .edge_en (edge_en)
   );

   vic_sampler u_sampler
   (
      .clk       (clk),
      .rst_n     (rst_n),
      .enable    (cfg_r.enable),
      .fmt       (cfg_r.fmt),
      .bypass    (cfg_r.bypass),
      .edge_en   (edge_en),
      .qual      (capture_qualifier),
      .bus       (capture_bus),
      .smp_valid (smp_valid),
      .smp       (smp)
   );

   assign cap_valid  = smp_valid;
   assign cap_sample = smp;

   // ==========================================================================
   // Checks
   int unsigned gap_r;
   logic        gap_ok_r;
   logic [7:0]  div_chk;

   assign div_chk = (cfg_r.div < VIC_DIV_MIN) ? VIC_DIV_MIN : cfg_r.div;

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         gap_r    <= 0;
         gap_ok_r <= 1'b0;
      end
      else
      begin
         gap_r    <= edge_en ? 1 : gap_r + 1;
         gap_ok_r <= edge_en ? (cfg_r.enable && cfg_r.clk_out) : (gap_ok_r && cfg_r.enable);
      end
   end

   sequence s_edge_qual;
      cfg_r.enable && edge_en && capture_qualifier;
   endsequence

   sequence s_captured;
      smp_valid && (smp.data[7:0] == $past(capture_bus[7:0]));
   endsequence

   sequence s_msg_edge;
      cfg_r.enable && edge_en && (cfg_r.fmt == VIC_FMT_MSG);
   endsequence

   a_pin_input_default: assert property (@(posedge clk) // [R1]
      !rst_n |=> !capture_clock_pin_oe)
      else $error("Capture clock pin not input after reset");

   a_sample_on_edge: assert property (@(posedge clk) disable iff (!rst_n) // [R2]
      s_edge_qual |=> s_captured ##1 (data_r == $past(smp.data)))
      else $error("Qualified edge not captured");

   a_discard_low: assert property (@(posedge clk) disable iff (!rst_n) // [R3]
      (edge_en && !capture_qualifier) or !edge_en |=> !smp_valid)
      else $error("Sample recorded without qualified edge");

   a_edge_spacing: assert property (@(posedge clk) disable iff (!rst_n) // [R4]
      edge_en |=> !edge_en)
      else $error("Capture edges closer than the rate limit");

   a_marker_bypass: assert property (@(posedge clk) disable iff (!rst_n) // [R5]
      s_msg_edge and cfg_r.bypass && !capture_qualifier && capture_bus[8]
      |=> smp.msg_start && !smp_valid)
      else $error("Start marker lost in bypass mode");

   a_div_period: assert property (@(posedge clk) disable iff (!rst_n) // [R6]
      edge_en && gap_ok_r && cfg_r.enable && cfg_r.clk_out |-> gap_r == div_chk)
      else $error("Output clock period differs from divisor");

   a_pin_drive: assert property (@(posedge clk) disable iff (!rst_n) // [R6]
      cfg_r.clk_out && edge_en |-> capture_clock_pin_oe && capture_clock_pin_o)
      else $error("Output clock not high at its rising edge");

   a_yuv_upper_zero: assert property (@(posedge clk) disable iff (!rst_n) // [R7]
      smp_valid && cfg_r.fmt == VIC_FMT_YUV8 |-> smp.data[9:8] == 2'b00)
      else $error("Upper lines leak into eight bit samples");

   a_ten_bit_raw_mode_upper: assert property (@(posedge clk) disable iff (!rst_n) // [R8]
      s_edge_qual and cfg_r.fmt == VIC_FMT_TEN_BIT_RAW_MODE
      |=> smp.data[9:8] == $past(capture_bus[9:8]))
      else $error("Ten bit raw sample lost upper bits");

   a_end_marker: assert property (@(posedge clk) disable iff (!rst_n) // [R9]
      s_msg_edge and capture_qualifier && capture_bus[9] |=> smp.msg_end ##1 end_r)
      else $error("End marker not flagged");

   a_cfg_locked: assert property (@(posedge clk) disable iff (!rst_n) // [R10]
      cfg_r.enable && $past(cfg_r.enable)
      |-> $stable(cfg_r.div) && $stable(cfg_r.fmt) && $stable(cfg_r.clk_out))
      else $error("Configuration changed during capture");

endmodule
`default_nettype wire

//--- test/tb.sv
// Self-checking bench for the capture port: AHB-Lite tasks plus a camera model.
// Assumes the one slave's hreadyout is fed back as hready.
`timescale 1ns/1ps
`default_nettype none
module tb;
   import vic_pkg::*;
   logic        clk, rst_n, hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, rdv;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic        pin_o, pin_oe, pin, cam_clk, cam_oe, qual, cap_valid;
   logic [9:0]  bus, last;
   vic_sample_t cap_sample;
   logic        seen_sta, seen_end;
   int          n_mismatch, total_checks, n_cap, hi, lo;

   assign hready = hreadyout;
   // Pulled low when nobody drives the clock pin
   assign pin = pin_oe ? pin_o : (cam_oe ? cam_clk : 1'b0);

   vic_top i_vic_top (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .capture_clock_pin_i(pin), .capture_clock_pin_o(pin_o),
      .capture_clock_pin_oe(pin_oe), .capture_qualifier(qual),
      .capture_bus(bus), .cap_valid(cap_valid), .cap_sample(cap_sample));

   vic_cam_model i_vic_cam_model (.clk(clk), .cam_clk(cam_clk),
      .cam_clk_oe(cam_oe), .qual(qual), .bus(bus));

   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // ==========================================================================
   // Capture monitor
   always @(posedge clk)
   begin
      if (cap_valid === 1'b1)
      begin
         n_cap = n_cap + 1;
         last  = cap_sample.data;
      end
      if (cap_sample.msg_start === 1'b1)
         seen_sta = 1'b1;
      if (cap_sample.msg_end === 1'b1)
         seen_end = 1'b1;
   end

   // ==========================================================================
   // Reporting
   task automatic give_verdict;
      $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // ==========================================================================
   // AHB-Lite single word transfers
   task automatic wait_rdy;
      int k;
      k = 0;
      do
      begin
         @(posedge clk);
         k++;
      end
      while (hreadyout !== 1'b1 && k < 50);
      if (k >= 50)
      begin
         n_mismatch++;
         give_verdict();
      end
   endtask

   task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] wd);
      @(posedge clk);
      hsel   <= 1'b1;
      haddr  <= a;
      hwrite <= w;
      htrans <= 2'b10;
      hsize  <= 3'b010;
      wait_rdy();
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      wait_rdy();
      rdv = hrdata;
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      xfer(a, 1'b1, d);
   endtask

   task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
      xfer(a, 1'b0, 32'h0000_0000);
      chk(rdv, exp);
   endtask

   task automatic send(input logic [9:0] d, input logic q);
      i_vic_cam_model.send(d, q);
      repeat (2) @(posedge clk);
   endtask

   // Count cycles in each level of the generated clock
   task automatic measure;
      int k;
      k  = 0;
      hi = 0;
      lo = 0;
      // Skip the first high phase, which may be cut short at switch-on
      while (pin_o !== 1'b1 && k < 50)
      begin
         @(posedge clk);
         k++;
      end
      while (pin_o === 1'b1 && k < 50)
      begin
         @(posedge clk);
         k++;
      end
      while (pin_o !== 1'b1 && lo < 50)
      begin
         @(posedge clk);
         lo++;
      end
      while (pin_o === 1'b1 && hi < 50)
      begin
         @(posedge clk);
         hi++;
      end
   endtask

   // ==========================================================================
   // Main sequence
   initial
   begin
      rst_n = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0;
      n_mismatch = 0;
      total_checks = 0;
      n_cap = 0;
      seen_sta = 1'b0;
      seen_end = 1'b0;
      last = 10'h000;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      // Reset state and unmapped offset
      @(posedge clk);
      chk({31'h0, pin_oe}, 32'h0);
      rd_chk(32'h00, 32'h0);
      rd_chk(32'h04, 32'h4);
      rd_chk(32'h08, 32'h0);
      rd_chk(32'h10, 32'h0);
      rd_chk(32'h20, 32'h0);
      // Byte mode: upper lines dropped, unqualified edge ignored
      wr(32'h00, 32'h01);
      send(10'h3A5, 1'b1);
      chk(n_cap, 32'h1);
      chk({22'h0, last}, 32'h0A5);
      send(10'h2F0, 1'b0);
      chk(n_cap, 32'h1);
      rd_chk(32'h10, 32'h1);
      rd_chk(32'h08, 32'h1);
      rd_chk(32'h0C, 32'h0A5);
      rd_chk(32'h08, 32'h0);
      // Ten bit raw; format locked while enabled
      wr(32'h00, 32'h00);
      wr(32'h00, 32'h11);
      send(10'h3A5, 1'b1);
      chk({22'h0, last}, 32'h3A5);
      wr(32'h00, 32'h21);
      rd_chk(32'h00, 32'h11);
      // Message mode markers
      wr(32'h00, 32'h00);
      wr(32'h00, 32'h21);
      send(10'h100, 1'b0);
      chk({31'h0, seen_sta}, 32'h0);
      send(10'h100, 1'b1);
      chk({31'h0, seen_sta}, 32'h1);
      send(10'h200, 1'b1);
      chk({31'h0, seen_end}, 32'h1);
      // Raw sample still unread, so the next sample raises overrun
      rd_chk(32'h08, 32'hF);
      wr(32'h08, 32'hE);
      rd_chk(32'h08, 32'h1);
      // Marker bypass: start and end markers without qualifier, no sample
      wr(32'h00, 32'h00);
      wr(32'h00, 32'h25);
      seen_sta = 1'b0;
      seen_end = 1'b0;
      hi = n_cap;
      send(10'h300, 1'b0);
      chk({31'h0, seen_sta}, 32'h1);
      chk({31'h0, seen_end}, 32'h1);
      chk(n_cap, hi);
      // Output clock mode, divide by six
      wr(32'h00, 32'h00);
      i_vic_cam_model.hold(10'h2C3, 1'b1);
      wr(32'h04, 32'h6);
      wr(32'h00, 32'h13);
      @(posedge clk);
      chk({31'h0, pin_oe}, 32'h1);
      measure();
      chk(hi, 32'h3);
      chk(lo, 32'h3);
      repeat (4) @(posedge clk);
      chk({22'h0, last}, 32'h2C3);
      give_verdict();
   end

   // Watchdog for a hung run
   initial
   begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      give_verdict();
   end
endmodule
`default_nettype wire

//--- test/vic_cam_model.sv
// Behavioural camera source on the far side of the capture port.
// Assumes clk is the core clock; every pin change lands just after a core edge.
`timescale 1ns/1ps
`default_nettype none
module vic_cam_model
(
   input  wire logic       clk,
   output logic            cam_clk,
   output logic            cam_clk_oe,
   output logic            qual,
   output logic [9:0]      bus
);
   initial
   begin
      cam_clk    = 1'b0;
      cam_clk_oe = 1'b1;
      qual       = 1'b0;
      bus        = 10'h155;
   end

   // ==========================================================================
   // One word per clock; clock stands low between words
   task automatic send(input logic [9:0] d, input logic q);
      @(posedge clk);
      bus     <= d;
      qual    <= q;
      repeat (2) @(posedge clk);
      cam_clk <= 1'b1;
      repeat (2) @(posedge clk);
      cam_clk <= 1'b0;
      qual    <= 1'b0;
      bus     <= ~d;    // Released bus must not echo the old word
   endtask

   // ==========================================================================
   // Port clocks us: drop our clock driver, hold the data
   task automatic hold(input logic [9:0] d, input logic q);
      @(posedge clk);
      cam_clk_oe <= 1'b0;
      qual       <= q;
      bus        <= d;
   endtask
endmodule
`default_nettype wire
